// ===== lpm_ctrl.sv
// low-power mode controller with apb register access
`timescale 1ns/1ps
`include "lpm_defs.svh"

module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int WAKE_W = 8
)
(
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              pclk_en,
	// apb slave
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// core side
	input  wire logic              wait_exec,
	input  wire logic              supervisor,
	input  wire logic              ext_reset_seen,
	output logic                   core_resume_irq,
	output logic                   core_reset_req,
	// wake requests from pins
	input  wire logic [WAKE_W-1:0] wake_req,
	// watchdog usage
	input  wire logic              system_watchdog_used,
	input  wire logic              indep_watchdog_used,
	// power and clock controls
	output logic                   osc_en,
	output logic                   cpu_clk_en,
	output logic                   periph_clk_en,
	output logic                   ram_clk_en,
	output logic                   system_watchdog_run,
	output logic                   indep_watchdog_run,
	output logic                   state_lost,
	output logic                   io_hold,
	output logic                   vdet_por_en,
	// interrupt
	output logic                   irq
);

	lpm_state_type              state_q;
	lpm_state_type              state_d;
	lpm_mode_type               mode_q;
	logic [WAKE_W-1:0]          wake_sync;
	logic [WAKE_W-1:0]          wake_en_q;
	logic [`LPM_EV_W-1:0]       int_stat_q;
	logic [`LPM_EV_W-1:0]       int_mask_q;
	logic [`LPM_EV_W-1:0]       ev;
	logic [31:0]                prdata_q;
	logic                       from_deep_q;
	logic                       deep_hold_q;
	logic                       deep_cause_q;
	logic                       io_hold_q;
	logic                       resume_irq_q;
	logic                       core_reset_q;
	logic                       osc_q;
	logic                       cpu_clk_q;
	logic                       periph_clk_q;
	logic                       ram_clk_q;
	logic                       wdt_run_q;
	logic                       lost_q;
	logic                       wr;
	logic                       rd_setup;
	logic                       addr_ok;
	logic                       wake_hit;
	logic                       refused;
	logic                       resume_wr;
	logic                       stop_osc;

	lpm_sync #(.W(WAKE_W)) u_wake_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.pclk_en  (pclk_en),
		.async_in (wake_req),
		.sync_out (wake_sync)
	);

	// apb decode; zero wait states
	assign wr       = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign addr_ok  = paddr == `LPM_OFS_MODE || paddr == `LPM_OFS_STATUS ||
	                  paddr == `LPM_OFS_IO_RESUME || paddr == `LPM_OFS_WAKE_EN ||
	                  paddr == `LPM_OFS_INT_STAT || paddr == `LPM_OFS_INT_MASK;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_ok;
	assign prdata   = prdata_q;

	assign resume_wr = wr && paddr == `LPM_OFS_IO_RESUME && pwdata[`LPM_RESUME_BIT];
	assign wake_hit  = |(wake_sync & wake_en_q);

	always_comb
	begin
		state_d = state_q;
		refused = 1'b0;
		case (state_q)
			ST_RUN:
				if (wait_exec)
				begin
					// standby with a watchdog running would freeze or lose it
					if (!supervisor || ((mode_q == LPM_SSTBY || mode_q == LPM_DSTBY) &&
					    (system_watchdog_used || indep_watchdog_used)))
						refused = 1'b1;
					else
						case (mode_q)
							LPM_SLEEP: state_d = ST_SLEEP;
							LPM_ACST:  state_d = ST_ACST;
							LPM_SSTBY: state_d = ST_SSTBY;
							LPM_DSTBY: state_d = ST_DSTBY;
							default:   state_d = ST_RUN;
						endcase
				end
			ST_SLEEP, ST_ACST, ST_SSTBY, ST_DSTBY:
				if (wake_hit)
					state_d = ST_WAKE;
			ST_WAKE:
				state_d = ST_RUN;
			default:
				state_d = ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= ST_RUN;
		else if (pclk_en)
			state_q <= state_d;
	end

	// remember whether the wake comes out of deep standby
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			from_deep_q <= 1'b0;
		else if (pclk_en && state_q == ST_RUN)
			from_deep_q <= state_d == ST_DSTBY;
	end

	// clock and retention controls follow the next state
	assign stop_osc = state_d == ST_SSTBY || state_d == ST_DSTBY;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_q        <= 1'b1;
			cpu_clk_q    <= 1'b1;
			periph_clk_q <= 1'b1;
			ram_clk_q    <= 1'b1;
			wdt_run_q    <= 1'b1;
			lost_q       <= 1'b0;
		end
		else if (pclk_en)
		begin
			osc_q        <= !stop_osc;
			cpu_clk_q    <= state_d == ST_RUN || state_d == ST_WAKE;
			periph_clk_q <= state_d == ST_RUN || state_d == ST_WAKE || state_d == ST_SLEEP;
			ram_clk_q    <= state_d == ST_RUN || state_d == ST_WAKE || state_d == ST_SLEEP;
			wdt_run_q    <= !stop_osc;
			lost_q       <= state_d == ST_DSTBY;
		end
	end

	// pin hold; after deep standby it outlives the wake until released
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			deep_hold_q <= 1'b0;
			io_hold_q   <= 1'b0;
		end
		else if (pclk_en)
		begin
			if (state_d == ST_DSTBY)
				deep_hold_q <= 1'b1;
			else if (resume_wr)
				deep_hold_q <= 1'b0;
			io_hold_q <= state_d == ST_ACST || state_d == ST_SSTBY || state_d == ST_DSTBY ||
			             (deep_hold_q && !resume_wr);
		end
	end

	// core restart: interrupt or reset depending on the mode left
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resume_irq_q <= 1'b0;
			core_reset_q <= 1'b0;
		end
		else if (pclk_en)
		begin
			resume_irq_q <= state_q == ST_WAKE && !from_deep_q;
			core_reset_q <= state_q == ST_WAKE && from_deep_q;
		end
	end

	// reset-cause flag; a deep-standby wake wins over a clearing reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			deep_cause_q <= 1'b0;
		else if (pclk_en)
		begin
			if (state_q == ST_WAKE && from_deep_q)
				deep_cause_q <= 1'b1;
			else if (ext_reset_seen)
				deep_cause_q <= 1'b0;
		end
	end

	// software-written registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q     <= LPM_RUN;
			wake_en_q  <= WAKE_W'(`LPM_WAKE_EN_RST);
			int_mask_q <= `LPM_INT_MASK_RST;
		end
		else if (pclk_en && wr)
		begin
			if (paddr == `LPM_OFS_MODE)
				mode_q <= lpm_mode_type'(pwdata[`LPM_MODE_W-1:0]);
			if (paddr == `LPM_OFS_WAKE_EN)
				wake_en_q <= pwdata[WAKE_W-1:0];
			if (paddr == `LPM_OFS_INT_MASK)
				int_mask_q <= pwdata[`LPM_EV_W-1:0];
		end
	end

	// sticky events, write one to clear, set wins
	always_comb
	begin
		ev                 = '0;
		ev[`LPM_EV_ENTER]  = pclk_en && state_q == ST_RUN && state_d != ST_RUN;
		ev[`LPM_EV_WAKE]   = pclk_en && state_q == ST_WAKE && !from_deep_q;
		ev[`LPM_EV_DEEP]   = pclk_en && state_q == ST_WAKE && from_deep_q;
		ev[`LPM_EV_REFUSE] = pclk_en && refused;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_stat_q <= '0;
		else if (pclk_en)
		begin
			if (wr && paddr == `LPM_OFS_INT_STAT)
				int_stat_q <= (int_stat_q & ~pwdata[`LPM_EV_W-1:0]) | ev;
			else
				int_stat_q <= int_stat_q | ev;
		end
	end

	// read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (pclk_en && rd_setup)
		begin
			prdata_q <= '0;
			case (paddr)
				`LPM_OFS_MODE:
					prdata_q[`LPM_MODE_W-1:0] <= mode_q;
				`LPM_OFS_STATUS:
				begin
					prdata_q[2:0]               <= state_q;
					prdata_q[`LPM_ST_CAUSE_BIT] <= deep_cause_q;
					prdata_q[`LPM_ST_HOLD_BIT]  <= io_hold_q;
				end
				`LPM_OFS_WAKE_EN:
					prdata_q[WAKE_W-1:0] <= wake_en_q;
				`LPM_OFS_INT_STAT:
					prdata_q[`LPM_EV_W-1:0] <= int_stat_q;
				`LPM_OFS_INT_MASK:
					prdata_q[`LPM_EV_W-1:0] <= int_mask_q;
				default:
					prdata_q <= '0;
			endcase
		end
	end

	assign osc_en              = osc_q;
	assign cpu_clk_en          = cpu_clk_q;
	assign periph_clk_en       = periph_clk_q;
	assign ram_clk_en          = ram_clk_q;
	assign system_watchdog_run = wdt_run_q;
	assign indep_watchdog_run  = wdt_run_q;
	assign state_lost          = lost_q;
	assign io_hold             = io_hold_q;
	assign vdet_por_en         = 1'b1;
	assign core_resume_irq     = resume_irq_q;
	assign core_reset_req      = core_reset_q;
	assign irq                 = |(int_stat_q & int_mask_q);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_entry_needs_wait: assert property (
		pclk_en && state_q == ST_RUN && state_d != ST_RUN |-> wait_exec && mode_q != LPM_RUN)
		else $error("low-power entry without wait");
	a_wake_exit: assert property (
		pclk_en && wake_hit && state_q != ST_RUN && state_q != ST_WAKE |=> state_q == ST_WAKE)
		else $error("enabled wake did not end low-power mode");
	a_resume_irq: assert property (
		pclk_en && state_q == ST_WAKE && !from_deep_q |=> core_resume_irq && !core_reset_req)
		else $error("no interrupt resume after wake");
	a_deep_reset: assert property (
		pclk_en && state_q == ST_WAKE && from_deep_q |=> core_reset_req && !core_resume_irq)
		else $error("no reset after deep standby wake");
	a_ram_clock: assert property (
		ram_clk_en |-> state_q == ST_RUN || state_q == ST_SLEEP || state_q == ST_WAKE)
		else $error("memory clocked in stop mode");
	a_acst_clocks: assert property (
		state_q == ST_ACST |-> osc_en && indep_watchdog_run && !cpu_clk_en && !periph_clk_en && io_hold)
		else $error("clock stop controls wrong");
	a_sstby_clocks: assert property (
		state_q == ST_SSTBY |-> !osc_en && !system_watchdog_run && !state_lost && io_hold)
		else $error("software standby controls wrong");
	a_deep_lost: assert property (
		state_q == ST_DSTBY |-> state_lost && io_hold && !osc_en && vdet_por_en)
		else $error("deep standby controls wrong");
	a_hold_until_resume: assert property (
		pclk_en && deep_hold_q && !resume_wr ##1 pclk_en |-> io_hold)
		else $error("pin hold released without software");
	a_cause_flag: assert property (
		core_reset_req |-> deep_cause_q)
		else $error("deep standby cause not recorded");
	a_refuse_user: assert property (
		pclk_en && state_q == ST_RUN && wait_exec && !supervisor |=> state_q == ST_RUN)
		else $error("wait accepted outside supervisor mode");

	c_sleep_entry: cover property (state_q == ST_RUN ##1 state_q == ST_SLEEP);
	c_deep_wake:   cover property (state_q == ST_DSTBY ##1 state_q == ST_WAKE ##1 core_reset_req);
	c_refused:     cover property (refused && pclk_en);
	c_hold_free:   cover property (deep_hold_q ##1 !deep_hold_q);

endmodule

// ===== lpm_defs.svh
// register offsets, field positions and reset values of the low-power mode controller
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define LPM_ADDR_W        8
`define LPM_OFS_MODE      8'h00
`define LPM_OFS_STATUS    8'h04
`define LPM_OFS_IO_RESUME 8'h08
`define LPM_OFS_WAKE_EN   8'h0c
`define LPM_OFS_INT_STAT  8'h10
`define LPM_OFS_INT_MASK  8'h14

`define LPM_MODE_W        3
`define LPM_ST_CAUSE_BIT  3
`define LPM_ST_HOLD_BIT   4
`define LPM_RESUME_BIT    0

`define LPM_EV_W          4
`define LPM_EV_ENTER      0
`define LPM_EV_WAKE       1
`define LPM_EV_DEEP       2
`define LPM_EV_REFUSE     3

`define LPM_WAKE_EN_RST   32'h0000_0000
`define LPM_INT_MASK_RST  4'h0

`endif

// ===== lpm_pkg.sv
// types of the low-power mode controller
package lpm_pkg;

	typedef enum logic [2:0]
	{
		LPM_RUN   = 3'h0,
		LPM_SLEEP = 3'h1,
		LPM_ACST  = 3'h2,
		LPM_SSTBY = 3'h3,
		LPM_DSTBY = 3'h4
	} lpm_mode_type;

	typedef enum logic [2:0]
	{
		ST_RUN   = 3'h0,
		ST_SLEEP = 3'h1,
		ST_ACST  = 3'h3,
		ST_SSTBY = 3'h2,
		ST_DSTBY = 3'h6,
		ST_WAKE  = 3'h4
	} lpm_state_type;

endpackage

// ===== lpm_sync.sv
// two-flop synchroniser for asynchronous wake request pins
`timescale 1ns/1ps

module lpm_sync
	import lpm_pkg::*;
#(
	parameter int W = 8
)
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         pclk_en,
	// signals
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end
				else if (pclk_en)
				begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			assign sync_out[i] = sync_q;
		end
	endgenerate

endmodule

// ===== lpm_core_model.sv
// processor core model issuing mode waits and counting restarts
`timescale 1ns/1ps

module lpm_core_model
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// from the controller
	input  wire logic core_resume_irq,
	input  wire logic core_reset_req,
	// to the controller
	output logic      wait_exec,
	output logic      supervisor
);
	int resume_cnt;
	int reset_cnt;

	initial
	begin
		wait_exec = 1'b0;
		supervisor = 1'b1;
	end

	// user code gets here through the break_trap handler, so priv is normally high
	task exec_wait(input logic priv);
		@(posedge pclk);
		supervisor <= priv;
		wait_exec <= 1'b1;
		@(posedge pclk);
		wait_exec <= 1'b0;
		supervisor <= 1'b1;
	endtask

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resume_cnt <= 0;
			reset_cnt <= 0;
		end
		else
		begin
			resume_cnt <= resume_cnt + int'(core_resume_irq);
			reset_cnt <= reset_cnt + int'(core_reset_req);
		end
	end
endmodule

// ===== test_low_power_mode_control.sv
// self-checking bench of the low-power mode controller
`timescale 1ns/1ps
`include "lpm_defs.svh"

module test_low_power_mode_control
	import lpm_pkg::*;
;
	typedef struct {lpm_mode_type m; logic [7:0] ctl; logic [2:0] st;} lpm_row_type;
	// ctl: osc, cpu, periph, ram, both watchdogs, state lost, pin hold
	lpm_row_type rows [4] = '{'{LPM_SLEEP, 8'hbc, 3'h1}, '{LPM_ACST, 8'h8d, 3'h3},
		'{LPM_SSTBY, 8'h01, 3'h2}, '{LPM_DSTBY, 8'h03, 3'h6}};
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        last_err;
	logic        wait_exec;
	logic        supervisor;
	logic        ext_reset_seen;
	logic        core_resume_irq;
	logic        core_reset_req;
	logic [7:0]  wake_req;
	logic        sys_wd;
	logic        ind_wd;
	wire  [7:0]  ctl;
	logic        vdet_por_en;
	logic        irq;
	logic        deep;
	int          fail_count;
	int          cmp_count;
	int          n0;
	int          n1;

	always #5 pclk = ~pclk;

	lpm_ctrl #(.WAKE_W(8)) dut (.pclk(pclk), .presetn(presetn), .pclk_en(clk_en),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_exec(wait_exec),
		.supervisor(supervisor), .ext_reset_seen(ext_reset_seen),
		.core_resume_irq(core_resume_irq), .core_reset_req(core_reset_req),
		.wake_req(wake_req), .system_watchdog_used(sys_wd), .indep_watchdog_used(ind_wd),
		.osc_en(ctl[7]), .cpu_clk_en(ctl[6]), .periph_clk_en(ctl[5]), .ram_clk_en(ctl[4]),
		.system_watchdog_run(ctl[3]), .indep_watchdog_run(ctl[2]), .state_lost(ctl[1]),
		.io_hold(ctl[0]), .vdet_por_en(vdet_por_en), .irq(irq));

	lpm_core_model core (.pclk(pclk), .presetn(presetn), .core_resume_irq(core_resume_irq),
		.core_reset_req(core_reset_req), .wait_exec(wait_exec), .supervisor(supervisor));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		apb(1'b1, a, d, unused);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		apb(1'b0, a, 32'h0, v);
		chk(n, e, v);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#500000;
		fail_count++;
		close_out;
	end

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite, ext_reset_seen, sys_wd, ind_wd} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wake_req = 8'h00;
		fail_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		chk("controls", 32'hfc, ctl);
		chk("vdet", 32'h1, vdet_por_en);
		chk("irq", 32'h0, irq);
		rd_chk("mode", `LPM_OFS_MODE, 32'h0);
		rd_chk("status", `LPM_OFS_STATUS, 32'h0);
		rd_chk("wake_en", `LPM_OFS_WAKE_EN, `LPM_WAKE_EN_RST);
		rd_chk("int_mask", `LPM_OFS_INT_MASK, 32'h0);
		rd_chk("unmapped", 8'h18, 32'h0);
		chk("pslverr", 32'h1, last_err);
		$display("test reset done");
		wr(`LPM_OFS_WAKE_EN, 32'h1);
		wr(`LPM_OFS_INT_MASK, 32'h2);
		foreach (rows[i])
		begin
			deep = (rows[i].m == LPM_DSTBY);
			wr(`LPM_OFS_MODE, 32'(rows[i].m));
			settle(2);
			chk("mode only", 32'hfc, ctl);
			core.exec_wait(1'b1);
			settle(1);
			chk("controls", rows[i].ctl, ctl);
			chk("vdet", 32'h1, vdet_por_en);
			rd_chk("status", `LPM_OFS_STATUS, {27'h0, rows[i].ctl[0], 1'b0, rows[i].st});
			n0 = core.resume_cnt;
			n1 = core.reset_cnt;
			@(posedge pclk);
			// wake held until the core counts a resume or a restart, for at most 20 cycles
			wake_req <= 8'h01;
			for (int k = 0; k < 20 && core.resume_cnt == n0 && core.reset_cnt == n1; k++)
				@(posedge pclk);
			wake_req <= 8'h00;
			settle(1);
			chk("resume", 32'(!deep), 32'(core.resume_cnt - n0));
			chk("restart", 32'(deep), 32'(core.reset_cnt - n1));
			chk("controls woken", 32'h0fc | 32'(deep), ctl);
			rd_chk("int_stat", `LPM_OFS_INT_STAT, deep ? 32'h5 : 32'h3);
			chk("irq", 32'(!deep), irq);
			wr(`LPM_OFS_INT_STAT, 32'hf);
			settle(1);
			chk("irq cleared", 32'h0, irq);
			if (deep)
			begin
				rd_chk("status held", `LPM_OFS_STATUS, 32'h18);
				wr(`LPM_OFS_IO_RESUME, 32'h1);
				settle(1);
				chk("io_hold", 32'h0, ctl[0]);
				rd_chk("status", `LPM_OFS_STATUS, 32'h08);
				@(posedge pclk);
				ext_reset_seen <= 1'b1;
				@(posedge pclk);
				ext_reset_seen <= 1'b0;
				rd_chk("cause cleared", `LPM_OFS_STATUS, 32'h0);
			end
			$display("test mode %0d done", i);
		end
		// standby with a watchdog in use is refused and flagged
		wr(`LPM_OFS_INT_MASK, 32'h8);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge pclk);
			sys_wd <= (j == 0);
			ind_wd <= (j == 1);
			wr(`LPM_OFS_MODE, j ? 32'h3 : 32'h4);
			core.exec_wait(1'b1);
			settle(1);
			chk("refused", 32'hfc, ctl);
			chk("irq refused", 32'h1, irq);
			wr(`LPM_OFS_INT_STAT, 32'h8);
			settle(1);
			chk("irq cleared", 32'h0, irq);
		end
		$display("test watchdog refusal done");
		@(posedge pclk);
		{sys_wd, ind_wd} <= 2'b00;
		wr(`LPM_OFS_MODE, 32'h1);
		core.exec_wait(1'b0);
		settle(1);
		chk("user wait", 32'hfc, ctl);
		rd_chk("int_stat", `LPM_OFS_INT_STAT, 32'h8);
		$display("test user wait done");
		// enable low: the write is lost, the wait is ignored and no event is logged
		@(posedge pclk);
		clk_en <= 1'b0;
		wr(`LPM_OFS_WAKE_EN, 32'hff);
		core.exec_wait(1'b1);
		settle(1);
		chk("frozen controls", 32'hfc, ctl);
		@(posedge pclk);
		clk_en <= 1'b1;
		rd_chk("wake_en frozen", `LPM_OFS_WAKE_EN, 32'h1);
		rd_chk("int_stat frozen", `LPM_OFS_INT_STAT, 32'h8);
		rd_chk("status frozen", `LPM_OFS_STATUS, 32'h0);
		$display("test clock enable done");
		close_out;
	end
endmodule
